// >>> pwm_pkg.sv
package pwm_pkg;
   localparam int gen_count = 2;
   localparam int width_bits = 16;
   localparam int cycle_bits = 24;
   // pulse width scale codes
   typedef enum logic [1:0] {
      scale_hundredths = 2'b00,
      scale_thousandths = 2'b01,
      scale_tenthousandths = 2'b10,
      scale_analog = 2'b11
   } scale_type;
   localparam logic [15:0] full_hundredths = 16'h0064;
   localparam logic [15:0] full_thousandths = 16'h03e8;
   localparam logic [15:0] full_tenthousandths = 16'h2710;
   localparam logic [15:0] full_analog = 16'h6c00;
   // time base codes
   typedef enum logic {
      base_ms = 1'b0,
      base_us = 1'b1
   } base_type;
   // generator use
   typedef enum logic {
      use_width_mod = 1'b0,
      pulse_train_mode = 1'b1
   } gen_use_type;
   typedef enum logic [1:0] {
      source_onboard = 2'b00,
      source_addon = 2'b01
   } source_type;
   // clock rate and time base units
   localparam int clk_mhz = 250;
   localparam int us_ns = 1000;
   localparam int clk_period_ns = 4;
   localparam int ticks_per_us = us_ns / clk_period_ns;
   localparam int ticks_per_ms = ticks_per_us * 1000;
   // output image word addresses
   localparam logic [15:0] width_addr_gen0 = 16'h03e8;
   localparam logic [15:0] width_addr_gen1 = 16'h03ea;
   // generator identifiers
   typedef logic [15:0] generator_identifier_type;
   localparam generator_identifier_type gen_id0 = 16'h0001;
   localparam generator_identifier_type gen_id1 = 16'h0002;
   // condition codes
   localparam logic [15:0] status_ok = 16'h0000;
   localparam logic [15:0] status_bad_id = 16'h80a1;
   localparam logic [15:0] access_err_lo = 16'h8022;
   localparam logic [15:0] access_err_hi = 16'h803a;
   // output pin positions within each board group
   localparam int pulse_pin0 = 0;
   localparam int pulse_pin1 = 2;
   localparam int out_bits = 4;
   // register port
   localparam int addr_bits = 4;
   localparam logic [3:0] reg_ctrl = 4'h0;
   localparam logic [3:0] reg_status = 4'h1;
   localparam logic [3:0] reg_irq_status = 4'h2;
   localparam logic [3:0] reg_irq_mask = 4'h3;
   localparam int irq_bits = 4;
   localparam int irq_bad_id = 0;
   localparam int irq_access = 1;
   localparam int irq_start = 2;
   localparam int irq_stop = 3;
endpackage

// >>> dual_pulse_width_generator.sv
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module dual_pulse_width_generator #(
   parameter int cycle_bits = pwm_pkg::cycle_bits,
   parameter logic [15:0] init_width0 = 16'h0000,
   parameter logic [15:0] init_width1 = 16'h0000
) (
   input wire logic clk_i, // 250 mhz clock
   input wire logic rst_i, // synchronous reset, high
   input wire logic run_i, // controller run mode request
   input wire logic call_en_i, // control call executes this cycle
   input wire pwm_pkg::generator_identifier_type call_id_i, // generator selected
   input wire logic call_enable_i, // 1 start, 0 stop
   output logic call_busy_o, // always low
   output logic [15:0] call_status_o, // condition code
   output logic call_success_flag_o, // call succeeded
   input wire logic err_valid_i, // code block raised an error
   input wire logic [15:0] err_code_i, // error code
   input wire logic err_handled_i, // block handles error itself
   output logic run_o, // controller in run mode
   input wire pwm_pkg::scale_type scale0_i, // width scale gen 0
   input wire pwm_pkg::scale_type scale1_i, // width scale gen 1
   input wire pwm_pkg::base_type base0_i, // time base gen 0
   input wire pwm_pkg::base_type base1_i, // time base gen 1
   input wire logic [cycle_bits-1:0] cycle0_i, // cycle time gen 0 in base units
   input wire logic [cycle_bits-1:0] cycle1_i, // cycle time gen 1 in base units
   input wire pwm_pkg::gen_use_type use0_i, // gen 0 use
   input wire pwm_pkg::gen_use_type use1_i, // gen 1 use
   input wire logic gen_on0_i, // gen 0 configured
   input wire logic gen_on1_i, // gen 1 configured
   input wire pwm_pkg::source_type source_i, // onboard or addon_output_board
   input wire logic [15:0] waddr0_i, // width word address gen 0
   input wire logic [15:0] waddr1_i, // width word address gen 1
   input wire logic img_we_i, // output image word write
   input wire logic [15:0] img_addr_i, // output image word address
   input wire logic [15:0] img_data_i, // output image word data
   input wire logic [pwm_pkg::out_bits-1:0] prog_out_i, // program output bits
   input wire logic [pwm_pkg::out_bits-1:0] force_en_i, // force enables
   input wire logic [pwm_pkg::out_bits-1:0] force_val_i, // force values
   output logic [pwm_pkg::out_bits-1:0] onboard_o, // onboard outputs
   output logic [pwm_pkg::out_bits-1:0] addon_o, // addon board outputs
   input wire logic [pwm_pkg::addr_bits-1:0] addr_i, // register address
   input wire logic [31:0] wdata_i, // register write data
   input wire logic wr_i, // write strobe
   input wire logic rd_i, // read strobe
   output logic [31:0] rdata_o, // read data
   output logic irq_o // interrupt level
);
   import pwm_pkg::*;

   logic [1:0] run_sync_reg;
   logic run_reg;
   logic [gen_count-1:0] active_reg;
   logic [15:0] width_reg [gen_count];
   logic [cycle_bits-1:0] unit_reg [gen_count];
   logic [cycle_bits-1:0] phase_reg [gen_count];
   logic [gen_count-1:0] pulse_reg;
   logic [15:0] status_reg;
   logic success_reg;
   logic [irq_bits-1:0] irq_status_reg;
   logic [irq_bits-1:0] irq_mask_reg;
   logic [irq_bits-1:0] irq_event;
   logic [31:0] rdata_reg;
   logic [gen_count-1:0] sw_stop_reg;
   logic access_err;
   logic id_ok;
   logic sel;
   logic run_rise;
   logic error_stop_reg;
   logic [gen_count-1:0] call_hit;
   logic [gen_count-1:0] width_hit;
   logic rd_irq_clear;

   function automatic logic [15:0] full_scale(input scale_type s);
      case (s)
         scale_hundredths: full_scale = full_hundredths;
         scale_thousandths: full_scale = full_thousandths;
         scale_tenthousandths: full_scale = full_tenthousandths;
         scale_analog: full_scale = full_analog;
         default: full_scale = full_hundredths;
      endcase
   endfunction

   function automatic logic [31:0] base_ticks(input base_type b);
      base_ticks = (b == base_us) ? 32'(ticks_per_us) : 32'(ticks_per_ms);
   endfunction

   // per-generator view of the configuration
   scale_type scale [gen_count];
   base_type base [gen_count];
   logic [cycle_bits-1:0] cycle [gen_count];
   logic [gen_count-1:0] usable;
   logic [15:0] waddr [gen_count];
   logic [15:0] init_w [gen_count];
   assign scale[0] = scale0_i;
   assign scale[1] = scale1_i;
   assign base[0] = base0_i;
   assign base[1] = base1_i;
   assign cycle[0] = cycle0_i;
   assign cycle[1] = cycle1_i;
   assign waddr[0] = waddr0_i;
   assign waddr[1] = waddr1_i;
   assign init_w[0] = init_width0;
   assign init_w[1] = init_width1;
   // width mode only when not pulse train
   assign usable[0] = gen_on0_i && (use0_i == use_width_mod);
   assign usable[1] = gen_on1_i && (use1_i == use_width_mod);

   // image writes aimed at each generator's width word
   always_comb begin
      width_hit = '0;
      for (int g = 0; g < gen_count; g++) begin
         width_hit[g] = img_we_i && (img_addr_i == waddr[g]);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_sync_reg <= 2'b00;
      end else begin
         run_sync_reg <= {run_sync_reg[0], run_i};
      end
   end

   assign access_err = err_valid_i && !err_handled_i && (err_code_i >= access_err_lo) && (err_code_i <= access_err_hi);

   // stop mode holds until the run request is dropped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         error_stop_reg <= 1'b0;
      end else if (access_err) begin
         error_stop_reg <= 1'b1;
      end else if (!run_sync_reg[1]) begin
         error_stop_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_reg <= 1'b0;
      end else if (access_err) begin
         run_reg <= 1'b0;
      end else begin
         run_reg <= run_sync_reg[1] && !error_stop_reg;
      end
   end
   assign run_rise = run_sync_reg[1] && !error_stop_reg && !run_reg && !access_err;
   assign run_o = run_reg;

   // control call decode
   assign id_ok = (call_id_i == gen_id0 && usable[0]) || (call_id_i == gen_id1 && usable[1]);
   assign sel = (call_id_i == gen_id1);

   // one-hot view of the generator a valid call selects
   always_comb begin
      call_hit = '0;
      for (int g = 0; g < gen_count; g++) begin
         call_hit[g] = call_en_i && id_ok && (sel == 1'(g));
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_reg <= status_ok;
         success_reg <= 1'b1;
      end else if (call_en_i) begin
         status_reg <= id_ok ? status_ok : status_bad_id;
         success_reg <= id_ok;
      end
   end
   assign call_busy_o = 1'b0;
   assign call_status_o = status_reg;
   assign call_success_flag_o = success_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         active_reg <= '0;
      end else begin
         for (int g = 0; g < gen_count; g++) begin
            if (!run_reg || !usable[g] || sw_stop_reg[g]) begin
               active_reg[g] <= 1'b0;
            end else if (call_hit[g]) begin
               // start or stop by enable input
               active_reg[g] <= call_enable_i;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int g = 0; g < gen_count; g++) begin
            width_reg[g] <= init_w[g];
         end
      end else begin
         for (int g = 0; g < gen_count; g++) begin
            if (run_rise) begin
               // reload initial width at stop to run
               width_reg[g] <= init_w[g];
            end else if (width_hit[g]) begin
               // word at configured address; no restart
               width_reg[g] <= img_data_i;
            end
         end
      end
   end

   // base unit prescaler and cycle phase counter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int g = 0; g < gen_count; g++) begin
            unit_reg[g] <= '0;
            phase_reg[g] <= '0;
         end
      end else begin
         for (int g = 0; g < gen_count; g++) begin
            if (!active_reg[g]) begin
               unit_reg[g] <= '0;
               phase_reg[g] <= '0;
            end else if (32'(unit_reg[g]) + 32'd1 >= base_ticks(base[g])) begin
               // unit is one ms or one us
               unit_reg[g] <= '0;
               // free running cycle; cycle from configuration only
               phase_reg[g] <= (phase_reg[g] + 1'b1 >= cycle[g]) ? '0 : phase_reg[g] + 1'b1;
            end else begin
               unit_reg[g] <= unit_reg[g] + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pulse_reg <= '0;
      end else begin
         for (int g = 0; g < gen_count; g++) begin
            // phase*full < cycle*width; scale sets full
            // wide products keep the compare exact
            // zero never high, full scale always high
            pulse_reg[g] <= active_reg[g] && (width_reg[g] >= full_scale(scale[g]) ||
               (48'(phase_reg[g]) * 48'(full_scale(scale[g]))) < (48'(cycle[g]) * 48'(width_reg[g])));
         end
      end
   end

   // output routing
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         onboard_o <= '0;
         addon_o <= '0;
      end else begin
         for (int b = 0; b < out_bits; b++) begin
            onboard_o[b] <= force_en_i[b] ? force_val_i[b] : prog_out_i[b];
            addon_o[b] <= force_en_i[b] ? force_val_i[b] : prog_out_i[b];
         end
         // pulse pins of first and second pair; override writes and force
         if (usable[0]) begin
            if (source_i == source_addon) begin
               addon_o[pulse_pin0] <= pulse_reg[0];
            end else begin
               onboard_o[pulse_pin0] <= pulse_reg[0];
            end
         end
         if (usable[1]) begin
            if (source_i == source_addon) begin
               addon_o[pulse_pin1] <= pulse_reg[1];
            end else begin
               onboard_o[pulse_pin1] <= pulse_reg[1];
            end
         end
      end
   end

   // register port and interrupts
   assign irq_event[irq_bad_id] = call_en_i && !id_ok;
   assign irq_event[irq_access] = access_err;
   assign irq_event[irq_start] = call_enable_i && run_reg && |(call_hit & ~active_reg & ~sw_stop_reg);
   assign irq_event[irq_stop] = call_en_i && id_ok && !call_enable_i;

   // read of the interrupt status register clears it
   assign rd_irq_clear = rd_i && (addr_i == reg_irq_status);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask_reg <= '0;
         sw_stop_reg <= '0;
      end else if (wr_i) begin
         if (addr_i == reg_irq_mask) begin
            irq_mask_reg <= wdata_i[irq_bits-1:0];
         end
         if (addr_i == reg_ctrl) begin
            sw_stop_reg <= wdata_i[gen_count-1:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_status_reg <= '0;
      end else if (rd_irq_clear) begin
         irq_status_reg <= irq_event;
      end else begin
         irq_status_reg <= irq_status_reg | irq_event;
      end
   end
   assign irq_o = |(irq_status_reg & irq_mask_reg);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_reg <= '0;
      end else if (rd_i) begin
         case (addr_i)
            reg_ctrl: rdata_reg <= 32'(sw_stop_reg);
            reg_status: rdata_reg <= {12'h000, run_reg, pulse_reg, active_reg, status_reg[14:0]};
            reg_irq_status: rdata_reg <= 32'(irq_status_reg);
            reg_irq_mask: rdata_reg <= 32'(irq_mask_reg);
            default: rdata_reg <= '0;
         endcase
      end else begin
         rdata_reg <= '0;
      end
   end
   assign rdata_o = rdata_reg;
endmodule

// >>> pwm_props.sv
`timescale 1ns/1ps
module pwm_props
   import pwm_pkg::*;
(
   input wire logic clk_i, // clock
   input wire logic rst_i, // sync reset
   input wire logic run_i, // run request
   input wire logic call_en_i, // call strobe
   input wire pwm_pkg::generator_identifier_type call_id_i, // selected id
   input wire logic call_busy_o, // busy
   input wire logic [15:0] call_status_o, // condition code
   input wire logic call_success_flag_o, // success
   input wire logic err_valid_i, // error strobe
   input wire logic [15:0] err_code_i, // error code
   input wire logic err_handled_i, // handled
   input wire logic run_o, // run state
   input wire pwm_pkg::gen_use_type use0_i, // gen 0 use
   input wire logic gen_on0_i, // gen 0 configured
   input wire logic rd_i, // read strobe
   input wire logic [31:0] rdata_o // read data
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence call_gen0;
      call_en_i && call_id_i == gen_id0;
   endsequence
   sequence call_bad;
      call_en_i && call_id_i != gen_id0 && call_id_i != gen_id1;
   endsequence
   busy_never_a: assert property (call_busy_o == 1'b0)
      else $error("busy seen high");
   bad_id_a: assert property (call_bad |=> call_status_o == status_bad_id && !call_success_flag_o)
      else $error("bad id not refused");
   good_call_a: assert property (call_gen0 ##0 (use0_i == use_width_mod && gen_on0_i && run_o)
      |=> call_status_o == status_ok && call_success_flag_o) else $error("good call not accepted");
   unusable_gen_a: assert property (call_gen0 ##0 (use0_i == pulse_train_mode || !gen_on0_i)
      |=> call_status_o == status_bad_id) else $error("unusable generator accepted");
   status_hold_a: assert property (!call_en_i |=> $stable(call_status_o) && $stable(call_success_flag_o))
      else $error("status changed without call");
   error_stop_a: assert property (err_valid_i && err_code_i >= access_err_lo && err_code_i <= access_err_hi
      && !err_handled_i |=> !run_o) else $error("access error did not stop");
   run_drop_a: assert property (!run_i [*4] |-> !run_o)
      else $error("run state without request");
   rdata_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
      else $error("read data outside read cycle");
endmodule
bind dual_pulse_width_generator pwm_props chk (.*);

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
   import pwm_pkg::*;
   typedef struct {logic [15:0] id; logic en; gen_use_type u; logic on; logic [15:0] st; logic fl;} row_type;
   logic clk_i, rst_i = 1'b1, run_i = 1'b0, call_en_i = 1'b0, call_enable_i = 1'b0, err_valid_i = 1'b0;
   logic err_handled_i = 1'b0, gen_on0_i = 1'b1, gen_on1_i = 1'b1, img_we_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic call_busy_o, call_success_flag_o, run_o, irq_o;
   logic [15:0] call_status_o, err_code_i = 16'h0, img_addr_i = 16'h0, img_data_i = 16'h0;
   logic [15:0] waddr0_i = width_addr_gen0, waddr1_i = width_addr_gen1;
   generator_identifier_type call_id_i = 16'h0;
   scale_type scale0_i = scale_hundredths, scale1_i = scale_thousandths;
   base_type base0_i = base_us, base1_i = base_us;
   gen_use_type use0_i = use_width_mod, use1_i = use_width_mod;
   source_type source_i = source_onboard;
   // onboard cycle of 10 us keeps within 100 kHz
   logic [cycle_bits-1:0] cycle0_i = 24'h00000a, cycle1_i = 24'h00000a;
   logic [out_bits-1:0] prog_out_i = 4'h0, force_en_i = 4'h0, force_val_i = 4'h0, onboard_o, addon_o;
   logic [addr_bits-1:0] addr_i = 4'h0;
   logic [31:0] wdata_i = 32'h0, rdata_o;
   int mismatches = 0;
   int samples_checked = 0;
   wire logic [out_bits-1:0] pins = (source_i == source_addon) ? addon_o : onboard_o;
   row_type rows [7] = '{'{gen_id0, 1'b1, use_width_mod, 1'b1, status_ok, 1'b1},
      '{gen_id1, 1'b1, use_width_mod, 1'b1, status_ok, 1'b1},
      '{16'h0003, 1'b1, use_width_mod, 1'b1, status_bad_id, 1'b0},
      '{16'h0000, 1'b1, use_width_mod, 1'b1, status_bad_id, 1'b0},
      '{gen_id0, 1'b1, pulse_train_mode, 1'b1, status_bad_id, 1'b0},
      '{gen_id0, 1'b1, use_width_mod, 1'b0, status_bad_id, 1'b0},
      '{gen_id0, 1'b1, use_width_mod, 1'b1, status_ok, 1'b1}};
   dual_pulse_width_generator #(.init_width0(16'h0032), .init_width1(16'h03e8)) dut (.*);
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 check(rdata_o, exp, "read data");
   endtask
   task automatic img_wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk_i);
      img_we_i <= 1'b1;
      img_addr_i <= a;
      img_data_i <= d;
      @(posedge clk_i);
      img_we_i <= 1'b0;
      repeat (1000) @(posedge clk_i);
   endtask
   task automatic do_call(input row_type r);
      @(posedge clk_i);
      call_en_i <= 1'b1;
      call_id_i <= r.id;
      call_enable_i <= r.en;
      use0_i <= r.u;
      gen_on0_i <= r.on;
      @(posedge clk_i);
      call_en_i <= 1'b0;
      #1 check(call_status_o, r.st, "status");
      check(call_success_flag_o, r.fl, "success flag");
      check(call_busy_o, 1'b0, "busy");
   endtask
   task automatic measure(input int b, input int n, input int exp_hi);
      int hi;
      int edges;
      logic last;
      hi = 0;
      edges = 0;
      @(posedge clk_i);
      #1;
      last = pins[b];
      repeat (n) begin
         @(posedge clk_i);
         #1;
         hi += int'(pins[b]);
         edges += int'(pins[b] !== last);
         last = pins[b];
      end
      check(hi, exp_hi, "high time");
      if (exp_hi == 0 || exp_hi == n) check(edges, 0, "edge count");
      $display("measure on pin %0d done", b);
   endtask
   task automatic wait_run(input logic v);
      for (int i = 0; i < 20 && run_o !== v; i++) begin
         @(posedge clk_i);
         #1;
      end
      check(run_o, v, "run state");
      if (run_o !== v) report_and_stop;
   endtask
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      run_i <= 1'b1;
      wait_run(1'b1);
      foreach (rows[i]) begin
         do_call(rows[i]);
         $display("call row %0d done", i);
      end
      repeat (1000) @(posedge clk_i);
      measure(pulse_pin0, 2500, 1250);
      measure(pulse_pin1, 500, 500);
      img_wr(width_addr_gen0, 16'h0014);
      measure(pulse_pin0, 2500, 500);
      img_wr(width_addr_gen0, 16'h0000);
      prog_out_i <= 4'hf;
      force_en_i <= 4'hf;
      force_val_i <= 4'hf;
      repeat (10) @(posedge clk_i);
      measure(pulse_pin0, 500, 0);
      measure(1, 100, 100);
      @(posedge clk_i);
      force_en_i <= 4'h0;
      waddr1_i <= 16'h0010;
      img_wr(16'h0010, 16'h01f4);
      measure(pulse_pin1, 2500, 1250);
      img_wr(width_addr_gen0, 16'h0064);
      measure(pulse_pin0, 300, 300);
      do_call('{gen_id0, 1'b0, use_width_mod, 1'b1, status_ok, 1'b1});
      repeat (10) @(posedge clk_i);
      measure(pulse_pin0, 300, 0);
      @(posedge clk_i);
      run_i <= 1'b0;
      wait_run(1'b0);
      @(posedge clk_i);
      // addon board needs a cycle of 50 us, set while stopped
      source_i <= source_addon;
      cycle0_i <= 24'h000032;
      cycle1_i <= 24'h000032;
      run_i <= 1'b1;
      wait_run(1'b1);
      do_call(rows[0]);
      do_call(rows[1]);
      repeat (1000) @(posedge clk_i);
      measure(pulse_pin0, 12500, 6250);
      measure(pulse_pin1, 500, 500);
      reg_wr(reg_ctrl, 32'h1);
      reg_rd(reg_ctrl, 32'h1);
      reg_rd(reg_status, 32'h000d0000);
      measure(pulse_pin0, 100, 0);
      reg_wr(reg_ctrl, 32'h0);
      $display("software stop test done");
      @(posedge clk_i);
      err_valid_i <= 1'b1;
      err_code_i <= access_err_lo;
      err_handled_i <= 1'b1;
      @(posedge clk_i);
      err_handled_i <= 1'b0;
      #1 check(run_o, 1'b1, "handled error");
      @(posedge clk_i);
      err_valid_i <= 1'b0;
      #1 check(run_o, 1'b0, "stop on error");
      repeat (5) @(posedge clk_i);
      #1 check(run_o, 1'b0, "stop holds");
      $display("error test done");
      reg_wr(reg_irq_mask, 32'h0);
      reg_rd(reg_irq_status, 32'hf);
      do_call(rows[2]);
      repeat (2) @(posedge clk_i);
      #1 check(irq_o, 1'b0, "masked interrupt");
      reg_rd(reg_irq_status, 32'h1);
      reg_wr(reg_irq_mask, 32'h1);
      reg_rd(reg_irq_mask, 32'h1);
      do_call(rows[2]);
      repeat (2) @(posedge clk_i);
      #1 check(irq_o, 1'b1, "interrupt raised");
      reg_rd(reg_irq_status, 32'h1);
      repeat (2) @(posedge clk_i);
      #1 check(irq_o, 1'b0, "interrupt cleared");
      reg_rd(4'h7, 32'h0);
      $display("interrupt test done");
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      #1 check(call_success_flag_o, 1'b1, "flag after reset");
      check(call_status_o, status_ok, "status after reset");
      reg_rd(reg_irq_mask, 32'h0);
      reg_rd(reg_irq_status, 32'h0);
      $display("reset test done");
      report_and_stop;
   end
endmodule
